// file: common/jtpd_params.svh
`ifndef JTPD_PARAMS_SVH
`define JTPD_PARAMS_SVH

// Core clock period in ns, and the debug clock division ratio
`define JTPD_CORE_CLK_NS 8
`define JTPD_DEBUG_CLOCK_OUT_DIV 3
`define JTPD_DEBUG_CLOCK_OUT_CNT_W 2

// Instruction register
`define JTPD_IR_W 5
`define JTPD_IR_BYPASS 5'h1f
`define JTPD_IR_IDCODE 5'h01
`define JTPD_IR_TRACE_CTRL 5'h02
`define JTPD_IR_CAPTURE 5'h01

// Data register layout
`define JTPD_DR_W 32
`define JTPD_CTRL_TRACE_BIT 0

// Trace word layout: nibble in [3:0], status in [12:4]
`define JTPD_NIB_W 4
`define JTPD_STAT_W 9
`define JTPD_WORD_W 13
`define JTPD_STAT_LSB 4

// Reset values of the trace pins
`define JTPD_NIB_RESET 4'hf
`define JTPD_STAT_RESET 9'h000

`endif

// file: common/jtpd_pkg.sv
package jtpd_pkg;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
		TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} jtpd_tap_type;

endpackage

// file: design/jtpd_port.sv
// Operation
// [RULE1] The test clock times instruction execution and serial shifting.
// [RULE2] With trace off, the shared input pin is the serial data input.
// [RULE3] With trace on, the shared pin is a debug interrupt that ends trace.
// [RULE4] With trace off, the shared output pin carries serial scan data.
// [RULE5] With trace on, the shared output pin carries trace nibble bit 0.
// [RULE6] Three further pins carry trace nibble bits 3 to 1.
// [RULE7] The controller steps on the mode select sampled at the test clock.
// [RULE8] Test reset low asynchronously clears controller and debug unit.
// [RULE9] With test reset deasserted, bus timeout detection is disabled.
// [RULE10] The debug clock is the core clock divided by three.
// [RULE11] Trace nibble and status change in step with the debug clock. Nibble bit 0 on the shared pin changes one core clock later.
// [RULE12] A nine-bit trace status bus is driven, all low from reset.
// [RULE13] The probe drives the test pins per the tap protocol.
`timescale 1ns/1ns
`include "jtpd_params.svh"

module jtpd_port
	import jtpd_pkg::*;
#(
	// Identification value is arbitrary
	parameter logic [31:0] ID_VALUE = 32'h0000_0001,
	parameter int DEBUG_CLOCK_OUT_DIV = `JTPD_DEBUG_CLOCK_OUT_DIV
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Test port pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi_debug_interrupt_in_n,
	input wire logic trst_n,
	output logic tdo_tpc0,
	output logic tdo_oe_n,
	// Trace pins
	output logic [2:0] trace_pc_nibble_hi,
	output logic [8:0] trace_status_bus,
	output logic debug_clock_out,
	// Trace words from the core
	input wire logic trace_in_valid,
	input wire logic [12:0] trace_in_data,
	output logic trace_in_ready,
	// Status
	output logic trace_mode,
	output logic bus_timeout_disable
);

	logic tck_s1_r, tck_s2_r, tck_s3_r;
	logic tms_s1_r, tms_s2_r;
	logic tdi_s1_r, tdi_s2_r;
	logic trst_s1_r, trst_s2_r;
	logic tck_rise, tck_fall;

	jtpd_tap_type tap_r, tap_nxt;
	logic [4:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
	logic [31:0] dr_sh_r, dr_sh_nxt;
	logic trace_r, trace_nxt;
	logic tdo_r, tdo_nxt, oe_n_r, oe_n_nxt;

	logic [12:0] buf_r [2];
	logic [12:0] buf_nxt [2];
	logic [1:0] cnt_r, cnt_nxt;
	logic rdy_r, rdy_nxt;
	logic [1:0] div_r, div_nxt;
	logic debug_clock_out_r, debug_clock_out_nxt;
	logic [3:0] nib_r, nib_nxt;
	logic [8:0] stat_r, stat_nxt;
	logic tmo_r;

	function automatic jtpd_tap_type tap_step(jtpd_tap_type s, logic m);
		case (s)
			TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_step = m ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_step = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_step = m ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_step = m ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_step = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_step = m ? TAP_UPD_IR : TAP_SHIFT_IR;
			default: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
		endcase
	endfunction

	// Pins are asynchronous to core_clk; tck edges are seen two stages late
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tck_s1_r <= 1'b0;
			tck_s2_r <= 1'b0;
			tck_s3_r <= 1'b0;
			tms_s1_r <= 1'b1;
			tms_s2_r <= 1'b1;
			tdi_s1_r <= 1'b1;
			tdi_s2_r <= 1'b1;
			trst_s1_r <= 1'b0;
			trst_s2_r <= 1'b0;
			tmo_r <= 1'b0;
		end else if (clk_en) begin
			tck_s1_r <= tck;
			tck_s2_r <= tck_s1_r;
			tck_s3_r <= tck_s2_r;
			tms_s1_r <= tms;
			tms_s2_r <= tms_s1_r;
			tdi_s1_r <= tdi_debug_interrupt_in_n;
			tdi_s2_r <= tdi_s1_r;
			trst_s1_r <= trst_n;
			trst_s2_r <= trst_s1_r;
			// [RULE9] timeout disable follows
			tmo_r <= trst_s2_r;
		end
	end

	// [RULE1] test clock edges
	assign tck_rise = tck_s2_r & ~tck_s3_r;
	assign tck_fall = ~tck_s2_r & tck_s3_r;

	always_comb begin
		tap_nxt = tap_r;
		ir_nxt = ir_r;
		ir_sh_nxt = ir_sh_r;
		dr_sh_nxt = dr_sh_r;
		trace_nxt = trace_r;
		tdo_nxt = tdo_r;
		oe_n_nxt = oe_n_r;
		// [RULE3] debug interrupt ends trace
		if (trace_r && !tdi_s2_r)
			trace_nxt = 1'b0;
		if (tck_rise) begin
			// [RULE7] step on sampled mode select
			tap_nxt = tap_step(tap_r, tms_s2_r);
			case (tap_r)
				TAP_RESET: begin
					ir_nxt = `JTPD_IR_IDCODE;
				end
				TAP_CAP_IR: begin
					ir_sh_nxt = `JTPD_IR_CAPTURE;
				end
				TAP_SHIFT_IR: begin
					// [RULE2] serial input into instruction
					ir_sh_nxt = {tdi_s2_r, ir_sh_r[4:1]};
				end
				TAP_UPD_IR: begin
					ir_nxt = ir_sh_r;
				end
				TAP_CAP_DR: begin
					if (ir_r == `JTPD_IR_IDCODE)
						dr_sh_nxt = ID_VALUE;
					else if (ir_r == `JTPD_IR_TRACE_CTRL)
						dr_sh_nxt = {31'h0, trace_r};
					else
						dr_sh_nxt = 32'h0;
				end
				TAP_SHIFT_DR: begin
					// [RULE2] serial input into data
					if (ir_r == `JTPD_IR_IDCODE)
						dr_sh_nxt = {tdi_s2_r, dr_sh_r[31:1]};
					else
						dr_sh_nxt = {31'h0, tdi_s2_r};
				end
				TAP_UPD_DR: begin
					// Software entry into trace beats a same-cycle interrupt
					if (ir_r == `JTPD_IR_TRACE_CTRL)
						trace_nxt = dr_sh_r[`JTPD_CTRL_TRACE_BIT];
				end
				default: begin
				end
			endcase
		end
		if (trace_r) begin
			// [RULE5] nibble bit 0 on shared pin
			tdo_nxt = nib_r[0];
			oe_n_nxt = 1'b0;
		end else if (tck_fall) begin
			// [RULE4] scan data out on falling edge
			tdo_nxt = (tap_r == TAP_SHIFT_IR) ? ir_sh_r[0] : dr_sh_r[0];
			oe_n_nxt = !(tap_r == TAP_SHIFT_IR || tap_r == TAP_SHIFT_DR);
		end
	end

	// [RULE8] asynchronous test reset
	always_ff @(posedge core_clk or negedge trst_n) begin
		if (!trst_n) begin
			tap_r <= TAP_RESET;
			ir_r <= `JTPD_IR_IDCODE;
			ir_sh_r <= 5'h00;
			dr_sh_r <= 32'h0;
			trace_r <= 1'b0;
			tdo_r <= 1'b1;
			oe_n_r <= 1'b1;
		end else if (reset) begin
			tap_r <= TAP_RESET;
			ir_r <= `JTPD_IR_IDCODE;
			ir_sh_r <= 5'h00;
			dr_sh_r <= 32'h0;
			trace_r <= 1'b0;
			tdo_r <= 1'b1;
			oe_n_r <= 1'b1;
		end else if (clk_en) begin
			tap_r <= tap_nxt;
			ir_r <= ir_nxt;
			ir_sh_r <= ir_sh_nxt;
			dr_sh_r <= dr_sh_nxt;
			trace_r <= trace_nxt;
			tdo_r <= tdo_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// Trace buffer and debug clock; at most one word leaves per debug clock period, and only in trace mode
	always_comb begin
		logic push, pop, tick;
		push = 1'b0;
		pop = 1'b0;
		tick = 1'b0;
		buf_nxt = buf_r;
		cnt_nxt = cnt_r;
		nib_nxt = nib_r;
		stat_nxt = stat_r;
		// [RULE10] divide by three
		if (div_r == 2'(DEBUG_CLOCK_OUT_DIV - 1)) begin
			div_nxt = 2'h0;
			tick = 1'b1;
		end else begin
			div_nxt = div_r + 2'h1;
		end
		debug_clock_out_nxt = (div_nxt == 2'h0);
		push = trace_in_valid && rdy_r;
		// [RULE11] update on debug clock rise
		if (tick) begin
			if (trace_r && cnt_r != 2'h0) begin
				pop = 1'b1;
				// [RULE6] upper nibble bits
				nib_nxt = buf_r[0][3:0];
				// [RULE12] status bus
				stat_nxt = buf_r[0][12:4];
			end else begin
				stat_nxt = `JTPD_STAT_RESET;
			end
		end
		if (pop) begin
			buf_nxt[0] = buf_r[1];
			cnt_nxt = cnt_nxt - 2'h1;
		end
		if (push)
			buf_nxt[cnt_nxt[0]] = trace_in_data;
		if (push)
			cnt_nxt = cnt_nxt + 2'h1;
		// Stalls the core when both entries wait
		rdy_nxt = (cnt_nxt != 2'h2);
	end

	always_ff @(posedge core_clk or negedge trst_n) begin
		if (!trst_n) begin
			buf_r[0] <= 13'h0;
			buf_r[1] <= 13'h0;
			cnt_r <= 2'h0;
			rdy_r <= 1'b0;
			div_r <= 2'h0;
			debug_clock_out_r <= 1'b0;
			nib_r <= `JTPD_NIB_RESET;
			stat_r <= `JTPD_STAT_RESET;
		end else if (reset) begin
			buf_r[0] <= 13'h0;
			buf_r[1] <= 13'h0;
			cnt_r <= 2'h0;
			rdy_r <= 1'b0;
			div_r <= 2'h0;
			debug_clock_out_r <= 1'b0;
			nib_r <= `JTPD_NIB_RESET;
			stat_r <= `JTPD_STAT_RESET;
		end else if (clk_en) begin
			buf_r <= buf_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
			div_r <= div_nxt;
			debug_clock_out_r <= debug_clock_out_nxt;
			nib_r <= nib_nxt;
			stat_r <= stat_nxt;
		end
	end

	assign tdo_tpc0 = tdo_r;
	assign tdo_oe_n = oe_n_r;
	assign trace_pc_nibble_hi = nib_r[3:1];
	assign trace_status_bus = stat_r;
	assign debug_clock_out = debug_clock_out_r;
	assign trace_in_ready = rdy_r;
	assign trace_mode = trace_r;
	assign bus_timeout_disable = tmo_r;

endmodule

// file: tb/jtpd_props.sv
`timescale 1ns/1ns
module jtpd_props (
	// Clock and resets
	input wire logic core_clk,
	input wire logic reset,
	input wire logic trst_n,
	input wire logic clk_en,
	// Pins
	input wire logic tdi_debug_interrupt_in_n,
	input wire logic [2:0] trace_pc_nibble_hi,
	input wire logic [8:0] trace_status_bus,
	input wire logic debug_clock_out,
	// Stream and status
	input wire logic trace_in_valid,
	input wire logic trace_in_ready,
	input wire logic trace_mode,
	input wire logic bus_timeout_disable
);
	default clocking @(posedge core_clk);
	endclocking
	// Test reset clears controller and trace state and a low enable freezes all, so most checks pause
	default disable iff (reset || !trst_n || !clk_en);
	property p_debug_clock_out;
		$rose(debug_clock_out) |=> !debug_clock_out [*2] ##1 debug_clock_out;
	endproperty
	a_debug_clock_out: assert property (p_debug_clock_out) else $error("debug_clock_out");
	property p_trst;
		disable iff (reset) !trst_n |-> !trace_mode &&
			trace_status_bus == 9'h000 && trace_pc_nibble_hi == 3'h7;
	endproperty
	a_trst: assert property (p_trst) else $error("trst");
	property p_bto_on;
		disable iff (reset) trst_n [*5] |-> bus_timeout_disable;
	endproperty
	a_bto_on: assert property (p_bto_on) else $error("bto");
	property p_bto_off;
		disable iff (reset) !trst_n [*5] |-> !bus_timeout_disable;
	endproperty
	a_bto_off: assert property (p_bto_off) else $error("bto");
	property p_debug_interrupt_in;
		trace_mode && !tdi_debug_interrupt_in_n |-> ##[1:4] !trace_mode;
	endproperty
	a_debug_interrupt_in: assert property (p_debug_interrupt_in) else $error("debug_interrupt_in");
	property p_sync;
		trace_mode && $changed({trace_pc_nibble_hi, trace_status_bus})
			|-> debug_clock_out;
	endproperty
	a_sync: assert property (p_sync) else $error("sync");
	property p_idle;
		!trace_mode [*4] |-> trace_status_bus == 9'h000;
	endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_full;
		(trace_in_valid && trace_in_ready && !trace_mode) [*2]
			|=> !trace_in_ready;
	endproperty
	a_full: assert property (p_full) else $error("full");
endmodule
bind jtpd_port jtpd_props u_props (.core_clk, .reset, .trst_n, .clk_en,
	.tdi_debug_interrupt_in_n, .trace_pc_nibble_hi, .trace_status_bus, .debug_clock_out,
	.trace_in_valid, .trace_in_ready, .trace_mode, .bus_timeout_disable);

// file: tb/jtpd_probe.sv
`timescale 1ns/1ns
module jtpd_probe (
	// Clock
	input wire logic core_clk,
	// Test pins
	input wire logic tdo_tpc0,
	input wire logic tdo_oe_n,
	output logic tck,
	output logic tms,
	output logic tdi_debug_interrupt_in_n,
	output logic trst_n
);
	// Pulled-up pins idle high, test reset starts low
	initial {tck, tms, tdi_debug_interrupt_in_n, trst_n} = 4'h6;
	task automatic step(input logic m, input logic di, output logic q);
		@(posedge core_clk);
		tck <= 1'b0;
		tms <= m;
		tdi_debug_interrupt_in_n <= di;
		repeat (4) @(posedge core_clk);
		// A released pin reads inverted here, so a late enable shows up
		q = tdo_oe_n ? !tdo_tpc0 : tdo_tpc0;
		tck <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic scan(input logic ir, input int n, input logic [31:0] di,
		output logic [31:0] dq);
		logic q;
		dq = 32'h0000_0000;
		step(1'b1, 1'b1, q);
		if (ir)
			step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, di[i], q);
			dq[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
	task automatic debug_interrupt_in();
		@(posedge core_clk);
		tdi_debug_interrupt_in_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		tdi_debug_interrupt_in_n <= 1'b1;
	endtask
	task automatic pin(input logic v);
		@(posedge core_clk);
		trst_n <= v;
	endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	// Identification value is arbitrary
	localparam logic [31:0] ID_V = 32'h5a3c_0f69;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic trace_in_valid = 1'b0;
	logic [12:0] trace_in_data = 13'h0000;
	logic tck, tms, tdi_debug_interrupt_in_n, trst_n, tdo_tpc0, tdo_oe_n, debug_clock_out;
	logic trace_in_ready, trace_mode, bus_timeout_disable, seen = 1'b0;
	logic [2:0] trace_pc_nibble_hi;
	logic [8:0] trace_status_bus;
	logic [31:0] d, r;
	logic [12:0] exp_q[$];
	int fails = 0;
	int total_checks = 0;
	wire logic [12:0] pin_w = {trace_pc_nibble_hi, tdo_tpc0, trace_status_bus};
	jtpd_port #(.ID_VALUE(ID_V)) u_dut (.core_clk, .reset, .clk_en,
		.tck, .tms, .tdi_debug_interrupt_in_n, .trst_n, .tdo_tpc0, .tdo_oe_n,
		.trace_pc_nibble_hi, .trace_status_bus, .debug_clock_out,
		.trace_in_valid, .trace_in_data, .trace_in_ready, .trace_mode,
		.bus_timeout_disable);
	jtpd_probe u_probe (.core_clk, .tdo_tpc0, .tdo_oe_n, .tck, .tms,
		.tdi_debug_interrupt_in_n, .trst_n);
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		total_checks++;
		if (v !== e) begin
			fails++;
			$display("CHECK FAILED %0t got %h want %h", $time, v, e);
		end
	endtask
	task automatic summarize();
		if (fails == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Pins carry the nibble high bits first, then bit 0, then status
	function automatic logic [12:0] pin_order(input logic [12:0] w);
		return {w[3:1], w[0], w[12:4]};
	endfunction
	task automatic send(input logic [12:0] w);
		trace_in_valid <= 1'b1;
		trace_in_data <= w;
		@(posedge core_clk);
		for (int n = 0; n < 40 && trace_in_ready !== 1'b1; n++)
			@(posedge core_clk);
		exp_q.push_back(pin_order(w));
	endtask
	task automatic idcode();
		logic b;
		u_probe.step(1'b0, 1'b1, b);
		u_probe.scan(1'b0, 32, $urandom, d);
		chk(d, ID_V);
	endtask
	// Bit 0 passes one more stage, so compare a clock after the tick
	always @(negedge core_clk) begin
		if (seen && trace_status_bus !== 9'h000 && exp_q.size() > 0)
			chk(pin_w, exp_q.pop_front());
		seen <= debug_clock_out && trace_mode;
	end
	initial begin
		r = $urandom(11);
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		u_probe.pin(1'b1);
		repeat (8) @(negedge core_clk);
		chk({trace_mode, tdo_oe_n, pin_w}, 15'h3e00);
		chk(bus_timeout_disable, 1'b1);
		idcode();
		u_probe.scan(1'b1, 5, 32'h1f, d);
		chk(d[4:0], 5'h01);
		r = $urandom;
		u_probe.scan(1'b0, 32, r, d);
		chk(d, {r[30:0], 1'b0});
		@(posedge core_clk);
		send(13'h1fff);
		send(13'h0010);
		trace_in_valid <= 1'b0;
		@(negedge core_clk);
		chk(trace_in_ready, 1'b0);
		u_probe.scan(1'b1, 5, 32'h02, d);
		u_probe.scan(1'b0, 1, 32'h1, d);
		repeat (2) @(negedge core_clk);
		chk({trace_mode, tdo_oe_n}, 2'b10);
		@(posedge core_clk);
		for (int i = 0; i < 12; i++)
			send({9'($urandom) | 9'h100, 4'($urandom)});
		trace_in_valid <= 1'b0;
		for (int i = 0; i < 60 && exp_q.size() > 0; i++)
			@(posedge core_clk);
		chk(exp_q.size(), 0);
		u_probe.debug_interrupt_in();
		chk(trace_mode, 1'b0);
		u_probe.scan(1'b0, 1, 32'h1, d);
		chk({trace_mode, d[0]}, 2'b10);
		u_probe.pin(1'b0);
		repeat (6) @(negedge core_clk);
		chk({trace_mode, bus_timeout_disable}, 2'b00);
		u_probe.pin(1'b1);
		idcode();
		// Enable low must hold the debug clock divider still
		@(posedge core_clk);
		clk_en <= 1'b0;
		@(negedge core_clk);
		r = {31'h0, debug_clock_out};
		for (int i = 0; i < 3; i++) begin
			@(negedge core_clk);
			chk(debug_clock_out, r[0]);
		end
		@(posedge core_clk);
		clk_en <= 1'b1;
		summarize();
	end
	// Roughly fourteen times the expected run
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		summarize();
	end
endmodule
